// [rtl/sbl_writer.sv]
// places decoded sector, status, subcode and corrector bytes into a block
// Function
// - header bytes 0..3 hold minutes, seconds, frame and the mode byte.
// - mode 0 all-zero, mode 1 data with codes, mode 2 plain data.
// - offsets 4..2339 hold the sector body, 2048 user plus 288 aux.
// - mode 0 body forced zero; modes 1 and 2 body stored as received.
// - offsets 2340..2351 hold sync: 00, ten FF bytes, 00.
// - offset 2355 holds compressed erasure flag count, no positions.
// - count value is low six bits times four to the top two bits.
// - resolution 1, 4, 16, 64 over ranges up to 4095.
// - offsets 2356..2451 written only by enabled subcode copy channel.
// - copy channel de-interleaves, or writes raw bytes in stream order.
// - Q bytes at 2452..2463, not separated out in raw mode.
// - corrector status byte copied into offsets 2464 and 2465.
// - input path writes offsets 0..2355 itself.
`timescale 1ns/1ps
`default_nettype none
module sbl_writer
	import sbl_pkg::*;
(
	// clock and reset
	input wire logic i_clk,
	input wire logic i_sys_rst,
	// drive input path, sector bytes sync first
	input wire logic i_in_valid,
	input wire logic [7:0] i_in_data,
	input wire logic i_in_erasure,
	input wire logic [sbl_pkg::BLK_W-1:0] i_in_blk,
	input wire logic [7:0] i_status_byte_zero,
	input wire logic [7:0] i_status_byte_one,
	input wire logic [7:0] i_status_byte_two,
	output logic o_in_ready,
	// error corrector status copy
	input wire logic i_corr_valid,
	input wire logic [7:0] i_corrector_status_byte,
	input wire logic [sbl_pkg::BLK_W-1:0] i_corr_blk,
	output logic o_corr_ready,
	// subcode copy channel
	input wire logic i_sub_enable,
	input wire logic i_sub_raw,
	input wire logic i_sub_valid,
	input wire logic i_sub_first,
	input wire logic [7:0] i_sub_data,
	input wire logic [sbl_pkg::BLK_W-1:0] i_sub_blk,
	output logic o_sub_ready,
	// buffer write port
	output logic o_wr_en,
	output logic [sbl_pkg::BLK_W-1:0] o_wr_blk,
	output logic [sbl_pkg::OFF_W-1:0] o_wr_off,
	output logic [7:0] o_wr_data
);
	import sbl_pkg::*;

	typedef struct packed {
		logic wr_en;
		logic [BLK_W-1:0] wr_blk;
		logic [OFF_W-1:0] wr_off;
		logic [7:0] wr_data;
		logic in_rdy;
		logic [11:0] in_idx;
		logic [BLK_W-1:0] in_blk;
		logic [7:0] mode;
		logic [11:0] tally;
		logic [2:0] tail;
		logic [7:0] st0;
		logic [7:0] st1;
		logic [7:0] st2;
		logic [1:0] corr_pend;
		logic [7:0] corr_data;
		logic [BLK_W-1:0] corr_blk;
		logic sub_full;
		logic [OFF_W-1:0] sub_off;
		logic [7:0] sub_data;
		logic [BLK_W-1:0] sub_blk;
		logic [3:0] sub_grp;
		logic [3:0] sub_pos;
		logic [6:0] sub_cnt;
		logic corr_rdy;
		logic sub_rdy;
	} sbl_state_t;

	sbl_state_t s_q;
	sbl_state_t s_d;
	logic [7:0] code;
	logic in_take;
	logic corr_take;
	logic sub_take;
	logic [3:0] grp;
	logic [3:0] pos;

	sbl_tally_enc u_enc
	(
		.i_tally(s_q.tally),
		.o_code(code)
	);

	assign in_take = i_in_valid & s_q.in_rdy;
	assign corr_take = i_corr_valid & (s_q.corr_pend == 2'h0);
	assign sub_take = i_sub_valid & ~s_q.sub_full;

	always_comb
	begin
		s_d = s_q;
		s_d.wr_en = 1'b0;
		grp = i_sub_first ? 4'h0 : s_q.sub_grp;
		pos = i_sub_first ? 4'h0 : s_q.sub_pos;
		// the tail has the port; input is held off until it drains
		if (s_q.tail != 3'h0)
		begin
			s_d.wr_en = 1'b1;
			s_d.wr_blk = s_q.in_blk;
			s_d.tail = s_q.tail - 3'h1;
			if (s_q.tail == TAIL_STEPS)
			begin
				s_d.wr_off = OFF_STATUS_BYTE_ZERO;
				s_d.wr_data = s_q.st0;
			end
			else if (s_q.tail == 3'h3)
			begin
				s_d.wr_off = OFF_STATUS_BYTE_ONE;
				s_d.wr_data = s_q.st1;
			end
			else if (s_q.tail == 3'h2)
			begin
				s_d.wr_off = OFF_STATUS_BYTE_TWO;
				s_d.wr_data = s_q.st2;
			end
			else
			begin
				s_d.wr_off = OFF_ERASE;
				s_d.wr_data = code;
			end
		end
		else if (in_take)
		begin
			s_d.wr_en = 1'b1;
			s_d.wr_blk = (s_q.in_idx == 12'h000) ? i_in_blk : s_q.in_blk;
			if (s_q.in_idx == 12'h000)
			begin
				s_d.in_blk = i_in_blk;
				s_d.tally = {11'h000, i_in_erasure};
			end
			else if (i_in_erasure && s_q.tally != TALLY_MAX)
				s_d.tally = s_q.tally + 12'h001;
			if (s_q.in_idx < IN_SYNC_LEN)
			begin
				// sync is regenerated, not copied from the stream
				s_d.wr_off = OFF_SYNC + s_q.in_idx;
				if (s_q.in_idx == 12'h000 || s_q.in_idx == IN_SYNC_LAST)
					s_d.wr_data = SYNC_EDGE;
				else
					s_d.wr_data = SYNC_MID;
			end
			else if (s_q.in_idx <= IN_HDR_END)
			begin
				s_d.wr_off = s_q.in_idx - IN_SYNC_LEN + OFF_HEADER;
				s_d.wr_data = i_in_data;
				if (s_q.in_idx == IN_HDR_END)
					s_d.mode = i_in_data;
			end
			else
			begin
				s_d.wr_off = s_q.in_idx - IN_SYNC_LEN;
				if (s_q.mode == MODE_ZERO)
					s_d.wr_data = 8'h00;
				else
					s_d.wr_data = i_in_data;
			end
			if (s_q.in_idx == IN_LAST)
			begin
				s_d.in_idx = 12'h000;
				s_d.tail = TAIL_STEPS;
				s_d.st0 = i_status_byte_zero;
				s_d.st1 = i_status_byte_one;
				s_d.st2 = i_status_byte_two;
			end
			else
				s_d.in_idx = s_q.in_idx + 12'h001;
		end
		else if (s_q.corr_pend != 2'h0)
		begin
			s_d.wr_en = 1'b1;
			s_d.wr_blk = s_q.corr_blk;
			s_d.wr_data = s_q.corr_data;
			// both copies carry the same byte
			s_d.wr_off = (s_q.corr_pend == CORR_COPIES) ? OFF_CORR :
				OFF_CORR + 12'h001;
			s_d.corr_pend = s_q.corr_pend - 2'h1;
		end
		else if (s_q.sub_full)
		begin
			s_d.wr_en = 1'b1;
			s_d.wr_blk = s_q.sub_blk;
			s_d.wr_off = s_q.sub_off;
			s_d.wr_data = s_q.sub_data;
			s_d.sub_full = 1'b0;
		end
		if (corr_take)
		begin
			s_d.corr_pend = CORR_COPIES;
			s_d.corr_data = i_corrector_status_byte;
			s_d.corr_blk = i_corr_blk;
		end
		// a disabled channel is drained but nothing lands in the block
		if (sub_take && i_sub_enable)
		begin
			s_d.sub_full = 1'b1;
			s_d.sub_data = i_sub_data;
			s_d.sub_blk = i_sub_blk;
			if (i_sub_raw)
			begin
				// raw: stream order, Q left mixed in
				s_d.sub_off = OFF_RW +
					(i_sub_first ? 12'h000 : {5'h00, s_q.sub_cnt});
			end
			else if (pos == 4'h0)
				s_d.sub_off = OFF_Q + {8'h00, grp};
			else
				s_d.sub_off = OFF_RW + {5'h00, grp, 3'h0} +
					{8'h00, pos} - 12'h001;
			s_d.sub_cnt = i_sub_first ? 7'h01 : s_q.sub_cnt + 7'h01;
			if (pos == SUB_GRP_LAST)
			begin
				s_d.sub_pos = 4'h0;
				s_d.sub_grp = (grp == SUB_GROUPS - 4'h1) ? 4'h0 : grp + 4'h1;
			end
			else
			begin
				s_d.sub_pos = pos + 4'h1;
				s_d.sub_grp = grp;
			end
		end
		s_d.in_rdy = (s_d.tail == 3'h0);
		// ready flags registered so the outputs leave straight from flops
		s_d.corr_rdy = (s_d.corr_pend == 2'h0);
		s_d.sub_rdy = ~s_d.sub_full;
	end

	always_ff @(posedge i_clk)
	begin
		if (i_sys_rst)
		begin
			s_q <= '0;
			s_q.in_rdy <= 1'b1;
			s_q.corr_rdy <= 1'b1;
			s_q.sub_rdy <= 1'b1;
		end
		else
			s_q <= s_d;
	end

	// offsets at OFF_WORK and above are never produced
	assign o_in_ready = s_q.in_rdy;
	assign o_corr_ready = s_q.corr_rdy;
	assign o_sub_ready = s_q.sub_rdy;
	assign o_wr_en = s_q.wr_en;
	assign o_wr_blk = s_q.wr_blk;
	assign o_wr_off = s_q.wr_off;
	assign o_wr_data = s_q.wr_data;
endmodule
`default_nettype wire

// [rtl/sbl_pkg.sv]
// shared constants for the sector buffer layout writer
package sbl_pkg;
	localparam int unsigned OFF_W = 12;
	localparam int unsigned BLK_W = 13;
	localparam logic [11:0] OFF_HEADER = 12'h000;
	localparam logic [11:0] OFF_BODY = 12'h004;
	localparam logic [11:0] OFF_SYNC = 12'h924;
	localparam logic [11:0] OFF_STATUS_BYTE_ZERO = 12'h930;
	localparam logic [11:0] OFF_STATUS_BYTE_ONE = 12'h931;
	localparam logic [11:0] OFF_STATUS_BYTE_TWO = 12'h932;
	localparam logic [11:0] OFF_ERASE = 12'h933;
	localparam logic [11:0] OFF_RW = 12'h934;
	localparam logic [11:0] OFF_Q = 12'h994;
	localparam logic [11:0] OFF_CORR = 12'h9A0;
	localparam logic [11:0] OFF_WORK = 12'h9A2;
	localparam logic [11:0] BLOCK_SIZE = 12'hA00;
	// incoming sector stream order: sync, header, body
	localparam logic [11:0] IN_SYNC_LEN = 12'h00C;
	localparam logic [11:0] IN_HDR_END = 12'h00F;
	localparam logic [11:0] IN_LAST = 12'h92F;
	localparam logic [11:0] IN_SYNC_LAST = 12'h00B;
	localparam logic [7:0] SYNC_EDGE = 8'h00;
	localparam logic [7:0] SYNC_MID = 8'hFF;
	localparam logic [7:0] MODE_ZERO = 8'h00;
	localparam logic [7:0] MODE_ECC = 8'h01;
	localparam logic [7:0] MODE_PLAIN = 8'h02;
	localparam logic [11:0] TALLY_MAX = 12'hFFF;
	localparam logic [11:0] RES1_LIM = 12'h040;
	localparam logic [11:0] RES4_LIM = 12'h100;
	localparam logic [11:0] RES16_LIM = 12'h400;
	// subcode holding buffer: 12 groups of one Q byte then 8 R-W bytes
	localparam logic [3:0] SUB_GROUPS = 4'hC;
	localparam logic [3:0] SUB_GRP_LAST = 4'h8;
	localparam logic [2:0] TAIL_STEPS = 3'h4;
	localparam logic [1:0] CORR_COPIES = 2'h2;
endpackage

// [rtl/sbl_tally_enc.sv]
// packs a 12-bit erasure tally into one mantissa/exponent byte
`timescale 1ns/1ps
`default_nettype none
module sbl_tally_enc
	import sbl_pkg::*;
(
	// raw tally
	input wire logic [11:0] i_tally,
	// packed byte
	output logic [7:0] o_code
);
	// truncates toward zero, so low bits are lost at large counts
	always_comb
	begin
		if (i_tally < RES1_LIM)
			o_code = {2'h0, i_tally[5:0]};
		else if (i_tally < RES4_LIM)
			o_code = {2'h1, i_tally[7:2]};
		else if (i_tally < RES16_LIM)
			o_code = {2'h2, i_tally[9:4]};
		else
			o_code = {2'h3, i_tally[11:6]};
	end
endmodule
`default_nettype wire

// [bench/sbl_props.sv]
// checker on the block write port of the sector writer
`timescale 1ns/1ps
`default_nettype none
module sbl_props
	import sbl_pkg::*;
(
	// watched ports
	input wire logic i_clk,
	input wire logic i_sys_rst,
	input wire logic i_in_valid,
	input wire logic i_corr_valid,
	input wire logic i_sub_valid,
	input wire logic i_sub_enable,
	input wire logic o_in_ready,
	input wire logic o_corr_ready,
	input wire logic o_sub_ready,
	input wire logic o_wr_en,
	input wire logic [11:0] o_wr_off,
	input wire logic [7:0] o_wr_data
);
	default clocking @(posedge i_clk);
	endclocking
	default disable iff (i_sys_rst);
	AST_WORK: assert property (o_wr_en |-> o_wr_off < OFF_WORK)
		else $error("work space written");
	AST_SYNC: assert property (o_wr_en && o_wr_off >= OFF_SYNC &&
		o_wr_off < OFF_STATUS_BYTE_ZERO |-> o_wr_data == ((o_wr_off == OFF_SYNC ||
		o_wr_off == 12'h92F) ? SYNC_EDGE : SYNC_MID))
		else $error("bad sync byte");
	AST_TAIL: assert property ($fell(o_in_ready) |-> o_wr_off == 12'h923
		##1 o_wr_en && o_wr_off == OFF_STATUS_BYTE_ZERO ##1 o_wr_off == OFF_STATUS_BYTE_ONE
		##1 o_wr_off == OFF_STATUS_BYTE_TWO ##1 o_wr_en && o_wr_off == OFF_ERASE)
		else $error("bad tail order");
	AST_RDY: assert property ($fell(o_in_ready) |=>
		!o_in_ready[*3] ##1 o_in_ready)
		else $error("bad input stall");
	AST_TAKE: assert property (i_in_valid && o_in_ready |=> o_wr_en)
		else $error("input byte not written");
	AST_RW: assert property (o_wr_en && o_wr_off >= OFF_RW &&
		o_wr_off < OFF_CORR |-> $past(i_sub_enable))
		else $error("subcode written while off");
	AST_SUBOFF: assert property (i_sub_valid && o_sub_ready &&
		!i_sub_enable |=> o_sub_ready)
		else $error("disabled subcode held");
	AST_CORR: assert property (i_corr_valid && o_corr_ready |->
		##[1:8] (o_wr_en && o_wr_off == OFF_CORR))
		else $error("corrector copy missing");
	AST_CORR2: assert property ($rose(o_corr_ready) |->
		o_wr_en && o_wr_off == 12'h9A1)
		else $error("second corrector copy missing");
endmodule
bind sbl_writer sbl_props u_props (.*);
`default_nettype wire

// [bench/sbl_mem_model.sv]
// buffer memory model holding every written block byte
`timescale 1ns/1ps
`default_nettype none
module sbl_mem_model
	import sbl_pkg::*;
(
	// write port
	input wire logic i_clk,
	input wire logic i_wr_en,
	input wire logic [sbl_pkg::BLK_W-1:0] i_wr_blk,
	input wire logic [sbl_pkg::OFF_W-1:0] i_wr_off,
	input wire logic [7:0] i_wr_data
);
	// sparse, so unwritten places read as unknown
	logic [7:0] mem [int];
	always @(posedge i_clk)
		if (i_wr_en === 1'b1)
			mem[{i_wr_blk, i_wr_off}] = i_wr_data;
endmodule
`default_nettype wire

// [bench/sbl_writer_tb.sv]
// self-checking bench for the sector buffer layout writer
`timescale 1ns/1ps
`default_nettype none
module sbl_writer_tb;
	import sbl_pkg::*;
	logic i_clk = 1'b0;
	logic i_sys_rst = 1'b1;
	logic i_in_valid, i_in_erasure, i_corr_valid, i_sub_enable, i_sub_raw;
	logic i_sub_valid, i_sub_first, o_in_ready, o_corr_ready, o_sub_ready;
	logic o_wr_en;
	logic [7:0] i_in_data, i_corrector_status_byte, i_sub_data, o_wr_data;
	logic [7:0] i_status_byte_zero, i_status_byte_one, i_status_byte_two;
	logic [BLK_W-1:0] i_in_blk, i_corr_blk, i_sub_blk, o_wr_blk;
	logic [OFF_W-1:0] o_wr_off;
	int fail_count = 0;
	int checks_done = 0;
	sbl_writer i_sbl_writer (.*);
	sbl_mem_model u_mem (.i_clk(i_clk), .i_wr_en(o_wr_en),
		.i_wr_blk(o_wr_blk), .i_wr_off(o_wr_off), .i_wr_data(o_wr_data));
	always #5 i_clk = ~i_clk;
	task automatic chk(string n, logic [7:0] e, logic [7:0] g);
		checks_done++;
		if (g !== e)
		begin
			fail_count++;
			$display("unexpected %s: expected %h seen %h", n, e, g);
		end
	endtask
	function automatic logic [7:0] enc(logic [11:0] v);
		if (v < 64) return {2'b00, v[5:0]};
		if (v < 256) return {2'b01, v[7:2]};
		if (v < 1024) return {2'b10, v[9:4]};
		return {2'b11, v[11:6]};
	endfunction
	function automatic logic [7:0] exp_b(int o, logic [7:0] m, int ne);
		logic [7:0] s;
		s = 8'(o + 12) ^ 8'h3C;
		if (o == 3) return m;
		if (o < 4) return s;
		if (o < 2340) return (m == MODE_ZERO) ? 8'h00 : s;
		if (o < 2352) return (o == 2340 || o == 2351) ? 8'h00 : 8'hFF;
		if (o < 2355) return 8'(8'hC0 + o - 2352);
		return enc(12'(ne));
	endfunction
	// sync bytes sent as junk: the writer must regenerate them
	task automatic sector(logic [12:0] b, logic [7:0] m, int ne);
		for (int i = 0; i < 2352; i++)
		begin
			@(negedge i_clk);
			i_in_valid = 1'b1;
			i_in_blk = b;
			i_in_data = (i == 15) ? m : 8'(i) ^ 8'h3C;
			i_in_erasure = i < ne;
			@(posedge i_clk);
			repeat (4) if (o_in_ready !== 1'b1) @(posedge i_clk);
		end
		@(negedge i_clk);
		i_in_valid = 1'b0;
		repeat (8) @(negedge i_clk);
		for (int o = 0; o < 2356; o++)
			chk($sformatf("blk %0d off %0d", b, o), exp_b(o, m, ne),
				u_mem.mem[{b, 12'(o)}]);
	endtask
	task automatic corr(logic [12:0] b, logic [7:0] s);
		@(negedge i_clk);
		i_corr_valid = 1'b1;
		i_corr_blk = b;
		i_corrector_status_byte = s;
		@(posedge i_clk);
		repeat (4) if (o_corr_ready !== 1'b1) @(posedge i_clk);
		@(negedge i_clk);
		i_corr_valid = 1'b0;
		repeat (4) @(negedge i_clk);
		chk("corrector copy 0", s, u_mem.mem[{b, OFF_CORR}]);
		chk("corrector copy 1", s, u_mem.mem[{b, 12'h9A1}]);
	endtask
	task automatic sub(logic [12:0] b, logic en, logic raw);
		int k;
		int a;
		i_sub_enable = en;
		i_sub_raw = raw;
		i_sub_blk = b;
		for (int n = 0; n < 108; n++)
		begin
			@(negedge i_clk);
			i_sub_valid = 1'b1;
			i_sub_first = n == 0;
			i_sub_data = 8'(n);
			@(posedge i_clk);
			repeat (4) if (o_sub_ready !== 1'b1) @(posedge i_clk);
		end
		@(negedge i_clk);
		i_sub_valid = 1'b0;
		repeat (4) @(negedge i_clk);
		for (int n = 0; n < 108; n++)
		begin
			a = raw ? 2356 + n : (n % 9 == 0) ? 2452 + n / 9 : 2355 + n - n / 9;
			k = {b, 12'(a)};
			chk($sformatf("subcode %0d", n), en ? 8'(n) : 8'h00,
				en ? u_mem.mem[k] : 8'(u_mem.mem.exists(k)));
		end
	endtask
	task automatic test_done();
		$display("checks %0d mismatches %0d", checks_done, fail_count);
		if (fail_count == 0 && checks_done > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	initial
	begin
		{i_in_valid, i_in_erasure, i_corr_valid, i_sub_valid} = 4'h0;
		{i_sub_enable, i_sub_raw, i_sub_first} = 3'h0;
		{i_in_data, i_corrector_status_byte, i_sub_data} = 24'h0;
		{i_in_blk, i_corr_blk, i_sub_blk} = 39'h0;
		i_status_byte_zero = 8'hC0;
		i_status_byte_one = 8'hC1;
		i_status_byte_two = 8'hC2;
		repeat (4) @(posedge i_clk);
		@(negedge i_clk);
		i_sys_rst = 1'b0;
		sector(13'h0001, MODE_ZERO, 0);
		sector(13'h0002, MODE_ECC, 63);
		sector(13'h0003, MODE_PLAIN, 64);
		sector(13'h0004, MODE_ECC, 300);
		sector(13'h0005, MODE_PLAIN, 1100);
		sector(13'h0006, MODE_ZERO, 2352);
		corr(13'h0006, 8'hA5);
		sub(13'h0001, 1'b1, 1'b0);
		sub(13'h0002, 1'b1, 1'b1);
		sub(13'h0003, 1'b0, 1'b0);
		test_done();
	end
	// whole run needs about 14700 cycles
	initial
	begin
		#400000;
		fail_count++;
		test_done();
	end
endmodule
`default_nettype wire
